// ==== rtl/scrs_params.svh ====
// timing counts and defaults for the card reset sequencer
// assumes inclusion by bare name from the sequencer module
`ifndef SCRS_PARAMS_SVH
`define SCRS_PARAMS_SVH
`define SCRS_IO_ASSERT_MAX 200
`define SCRS_ANSWER_MIN 400
`define SCRS_ANSWER_MAX 40000
`define SCRS_RST_LOW_MIN 40000
`define SCRS_RST_HIGH_MIN 40000
`define SCRS_CLK_DIV 4
`endif

// ==== rtl/scrs_pkg.sv ====
// types shared by the card reset sequencer
// assumes nothing beyond the params header
package scrs_pkg;
    typedef enum logic [2:0] {
        SCRS_IDLE = 3'b000,
        SCRS_CLK_RUN = 3'b001,
        SCRS_RST_LOW = 3'b011,
        SCRS_WAIT_ANS = 3'b010,
        SCRS_DONE = 3'b110,
        SCRS_TIMEOUT = 3'b111
    } scrs_state_t;

    typedef struct packed {
        logic answered;
        logic timeout;
        logic busy;
    } scrs_status_t;
endpackage

// ==== rtl/scrs_sequencer.sv ====
// card activation and reset sequencer: clock start, io assert, reset release, answer window
// assumes card io input is asynchronous to clk; card clock is derived from clk by a divider
`timescale 1ns/10ps
`include "scrs_params.svh"
module scrs_sequencer #(
    parameter int CLK_DIV = `SCRS_CLK_DIV,
    parameter int IO_ASSERT_CYC = `SCRS_IO_ASSERT_MAX,
    parameter int ANS_MIN_CYC = `SCRS_ANSWER_MIN,
    parameter int ANS_MAX_CYC = `SCRS_ANSWER_MAX,
    parameter int RST_LOW_CYC = `SCRS_RST_LOW_MIN,
    parameter int RST_HIGH_CYC = `SCRS_RST_HIGH_MIN
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic reset_line_mode,
    input wire logic card_io_line_in,
    output logic card_io_line_out,
    output logic card_io_line_oe,
    output logic card_clock_out,
    output logic card_reset_out,
    output scrs_pkg::scrs_status_t status
);
    if (CLK_DIV < 2 || CLK_DIV > 512 || CLK_DIV % 2 != 0 || IO_ASSERT_CYC < 1
        || ANS_MIN_CYC >= ANS_MAX_CYC || RST_LOW_CYC <= IO_ASSERT_CYC
        || ANS_MAX_CYC >= 65535 || RST_LOW_CYC >= 65536
        || RST_HIGH_CYC > ANS_MAX_CYC) begin : g_bad_params
        $error("scrs_sequencer: unsupported parameters");
    end

    localparam logic [15:0] IO_C = 16'(IO_ASSERT_CYC);
    localparam logic [15:0] AMIN_C = 16'(ANS_MIN_CYC);
    localparam logic [15:0] AMAX_C = 16'(ANS_MAX_CYC);
    localparam logic [15:0] RLOW_C = 16'(RST_LOW_CYC);
    localparam logic [15:0] RHIGH_C = 16'(RST_HIGH_CYC);
    localparam logic [7:0] HALF_C = 8'(CLK_DIV / 2 - 1);

    scrs_pkg::scrs_state_t state_ff;
    logic [7:0] div_ff;
    logic card_edge;
    logic [15:0] cyc_ff;
    logic io_s1_ff, io_s2_ff, io_s3_ff;
    logic io_fall;
    logic mode_ff;

    // two-stage sync, third stage only for edge detect
    always_ff @(posedge clk) begin
        if (srst) begin
            io_s1_ff <= 1'b1;
            io_s2_ff <= 1'b1;
            io_s3_ff <= 1'b1;
        end else begin
            io_s1_ff <= card_io_line_in;
            io_s2_ff <= io_s1_ff;
            io_s3_ff <= io_s2_ff;
        end
    end
    assign io_fall = io_s3_ff & ~io_s2_ff;

    wire running = (state_ff != scrs_pkg::SCRS_IDLE) && (state_ff != scrs_pkg::SCRS_TIMEOUT);
    assign card_edge = running && (div_ff == HALF_C) && !card_clock_out;

    // done keeps the card clocked and is idle for the user, but a reset-line card
    // only restarts once the reset-high hold has run out, so it cannot be cut short
    wire seq_busy = running && (state_ff != scrs_pkg::SCRS_DONE);
    wire can_start = (state_ff == scrs_pkg::SCRS_IDLE) || (state_ff == scrs_pkg::SCRS_TIMEOUT)
        || (state_ff == scrs_pkg::SCRS_DONE && (!mode_ff || cyc_ff >= RHIGH_C));
    wire take = start && can_start;
    // internal cards count the time-zero edge itself; one off gives cycles after reference
    wire [15:0] ans_cyc = mode_ff ? cyc_ff : cyc_ff - 16'h0001;

    // card clock divider, toggles the card clock every CLK_DIV/2 clk cycles
    // a restart from done parks the clock low first so time zero is a clean first edge
    always_ff @(posedge clk) begin
        if (srst || !running || take) begin
            div_ff <= 8'h00;
            card_clock_out <= 1'b0;
        end else if (div_ff == HALF_C) begin
            div_ff <= 8'h00;
            card_clock_out <= ~card_clock_out;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // mode latched at start so a change mid-sequence cannot corrupt it
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_ff <= 1'b0;
        end else if (take) begin
            mode_ff <= reset_line_mode;
        end
    end

    // card cycle counter, restarted when a start is taken and at reset release
    always_ff @(posedge clk) begin
        if (srst || !running || take) begin
            cyc_ff <= 16'h0000;
        end else if (state_ff == scrs_pkg::SCRS_RST_LOW && card_edge && cyc_ff == RLOW_C) begin
            cyc_ff <= 16'h0000;
        end else if (card_edge && cyc_ff != 16'hFFFF) begin
            cyc_ff <= cyc_ff + 16'h0001;
        end
    end

    // sequence control
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= scrs_pkg::SCRS_IDLE;
        end else begin
            case (state_ff)
                scrs_pkg::SCRS_IDLE, scrs_pkg::SCRS_TIMEOUT, scrs_pkg::SCRS_DONE: begin
                    if (take) begin
                        state_ff <= scrs_pkg::SCRS_CLK_RUN;
                    end
                end
                scrs_pkg::SCRS_CLK_RUN: begin
                    if (card_edge && cyc_ff == IO_C) begin
                        state_ff <= mode_ff ? scrs_pkg::SCRS_RST_LOW
                                            : scrs_pkg::SCRS_WAIT_ANS;
                    end
                end
                scrs_pkg::SCRS_RST_LOW: begin
                    if (card_edge && cyc_ff == RLOW_C) begin
                        state_ff <= scrs_pkg::SCRS_WAIT_ANS;
                    end
                end
                scrs_pkg::SCRS_WAIT_ANS: begin
                    if (io_fall && ans_cyc >= AMIN_C) begin
                        state_ff <= scrs_pkg::SCRS_DONE;
                    end else if (ans_cyc > AMAX_C) begin
                        state_ff <= scrs_pkg::SCRS_TIMEOUT;
                    end
                end
                default: state_ff <= scrs_pkg::SCRS_IDLE;
            endcase
        end
    end

    // pins: io released high by driver after the assert count, reset held low until release
    always_ff @(posedge clk) begin
        if (srst) begin
            card_io_line_out <= 1'b1;
            card_io_line_oe <= 1'b0;
            card_reset_out <= 1'b0;
            status <= '0;
        end else begin
            card_io_line_out <= 1'b1;
            // io pulled up by driving high once past the assert count
            card_io_line_oe <= (state_ff == scrs_pkg::SCRS_CLK_RUN && card_edge && cyc_ff == IO_C);
            // high through done; a timeout, idle or a taken restart returns it low
            card_reset_out <= mode_ff && (state_ff == scrs_pkg::SCRS_WAIT_ANS
                                          || (state_ff == scrs_pkg::SCRS_DONE && !take));
            status.busy <= seq_busy;
            if (take) begin
                status.timeout <= 1'b0;
                status.answered <= 1'b0;
            end else begin
                if (state_ff == scrs_pkg::SCRS_WAIT_ANS && !(io_fall && ans_cyc >= AMIN_C)
                    && ans_cyc > AMAX_C) begin
                    status.timeout <= 1'b1;
                end
                if (state_ff == scrs_pkg::SCRS_WAIT_ANS && io_fall && ans_cyc >= AMIN_C) begin
                    status.answered <= 1'b1;
                end
            end
        end
    end

    a_io_assert_bound: assert property (@(posedge clk) disable iff (srst)
        (state_ff == scrs_pkg::SCRS_CLK_RUN) |-> cyc_ff <= IO_C)
        else $error("io not asserted in time");
    a_io_single: assert property (@(posedge clk) disable iff (srst)
        card_io_line_oe |=> !card_io_line_oe)
        else $error("io assert longer than one cycle");
    a_rst_low_hold: assert property (@(posedge clk) disable iff (srst)
        (state_ff == scrs_pkg::SCRS_RST_LOW) |-> !card_reset_out)
        else $error("reset rose early");
    a_rst_release: assert property (@(posedge clk) disable iff (srst)
        $rose(card_reset_out) |-> $past(state_ff) == scrs_pkg::SCRS_WAIT_ANS && mode_ff)
        else $error("reset released outside window");
    a_rst_high_hold: assert property (@(posedge clk) disable iff (srst)
        $fell(card_reset_out) |-> !running || $past(state_ff) == scrs_pkg::SCRS_TIMEOUT
        || $past(state_ff) == scrs_pkg::SCRS_DONE || $past(start))
        else $error("reset dropped mid sequence");
    a_rst_high_span: assert property (@(posedge clk) disable iff (srst)
        $fell(card_reset_out) && $past(state_ff) == scrs_pkg::SCRS_DONE
        |-> $past(cyc_ff) >= RHIGH_C)
        else $error("reset high hold cut short");
    a_ans_window: assert property (@(posedge clk) disable iff (srst)
        $rose(status.answered) |-> $past(ans_cyc) >= AMIN_C && $past(ans_cyc) <= AMAX_C)
        else $error("answer accepted outside window");
    a_early_ignored: assert property (@(posedge clk) disable iff (srst)
        (state_ff == scrs_pkg::SCRS_WAIT_ANS && io_fall && ans_cyc < AMIN_C)
        |=> state_ff == scrs_pkg::SCRS_WAIT_ANS)
        else $error("early answer accepted");
    a_timeout_sticky: assert property (@(posedge clk) disable iff (srst)
        status.timeout && !start |=> status.timeout)
        else $error("timeout flag lost");
    a_timeout_halt: assert property (@(posedge clk) disable iff (srst)
        status.timeout && !start |=> !card_clock_out)
        else $error("clock runs after timeout");
    a_halt_state: assert property (@(posedge clk) disable iff (srst)
        (state_ff == scrs_pkg::SCRS_TIMEOUT && !start) |=> state_ff == scrs_pkg::SCRS_TIMEOUT)
        else $error("sequence left halt without restart");
    a_clk_starts: assert property (@(posedge clk) disable iff (srst)
        take |=> ##[1:4] card_clock_out)
        else $error("card clock did not start");
    a_mode_select: assert property (@(posedge clk) disable iff (srst)
        (state_ff == scrs_pkg::SCRS_RST_LOW) |-> mode_ff)
        else $error("reset phase in internal mode");

    c_internal_done: cover property (@(posedge clk) !mode_ff && $rose(status.answered));
    c_line_done: cover property (@(posedge clk) mode_ff && $rose(status.answered));
    c_timeout: cover property (@(posedge clk) $rose(status.timeout));
    c_release: cover property (@(posedge clk) $rose(card_reset_out));
    c_held_restart: cover property (@(posedge clk)
        state_ff == scrs_pkg::SCRS_DONE && start && !take);
endmodule

// ==== verification/scrs_card_model.sv ====
// behavioural card: answers on the io line a set number of card clocks after its reference
// assumes the io line has a pull-up and the device only ever drives it high
`timescale 1ns/10ps
module scrs_card_model (
    input wire logic clk,
    input wire logic arm,
    input wire logic ans_en,
    input wire logic [15:0] ans_dly,
    input wire logic reset_line_mode,
    input wire logic card_clock_out,
    input wire logic card_reset_out,
    input wire logic card_io_line_out,
    input wire logic card_io_line_oe,
    output logic card_io_line_in
);
    logic clk_ff;
    logic rst_ff;
    logic [15:0] cnt_ff;
    logic pull_low;
    always @(posedge clk) begin
        clk_ff <= card_clock_out;
        rst_ff <= card_reset_out;
        if (arm || (card_reset_out && !rst_ff)) begin
            cnt_ff <= 16'h0000;
        end else if (card_clock_out && !clk_ff) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
    // in reset-line mode silent while its reset is low; held low two card clocks so the synchroniser sees it
    assign pull_low = ans_en && (cnt_ff >= ans_dly) && (cnt_ff < ans_dly + 16'h0002)
        && (!reset_line_mode || card_reset_out);
    assign card_io_line_in = (card_io_line_oe ? card_io_line_out : 1'b1) & ~pull_low;
endmodule

// ==== verification/scrs_sequencer_tb.sv ====
// self-checking bench for the card reset sequencer with short counts
// assumes the card model on the io line; inputs change on the falling edge
`timescale 1ns/10ps
module scrs_sequencer_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic reset_line_mode = 1'b0;
    logic card_io_line_in, card_io_line_out, card_io_line_oe, card_clock_out, card_reset_out;
    scrs_pkg::scrs_status_t status;
    logic arm = 1'b0;
    logic ans_en = 1'b0;
    logic [15:0] ans_dly = 16'h0000;
    int mismatches = 0;
    int tests_run = 0;
    int edges, io_at, rise_at, rst_drop;
    always #2.5 clk = ~clk;
    scrs_sequencer #(.IO_ASSERT_CYC(4), .ANS_MIN_CYC(8), .ANS_MAX_CYC(40),
        .RST_LOW_CYC(20), .RST_HIGH_CYC(20)) u_scrs_sequencer (.clk(clk), .srst(srst),
        .start(start), .reset_line_mode(reset_line_mode), .card_io_line_in(card_io_line_in),
        .card_io_line_out(card_io_line_out), .card_io_line_oe(card_io_line_oe),
        .card_clock_out(card_clock_out), .card_reset_out(card_reset_out), .status(status));
    scrs_card_model u_scrs_card_model (.clk(clk), .arm(arm), .ans_en(ans_en),
        .ans_dly(ans_dly), .reset_line_mode(reset_line_mode), .card_clock_out(card_clock_out),
        .card_reset_out(card_reset_out), .card_io_line_out(card_io_line_out),
        .card_io_line_oe(card_io_line_oe), .card_io_line_in(card_io_line_in));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one whole activation; the loop bound stands in for a hang check per sequence
    task automatic run_seq(input logic mode, input logic en, input logic [15:0] dly);
        logic clk_q;
        int n;
        clk_q = 1'b0;
        edges = 0;
        io_at = -1;
        rise_at = -1;
        rst_drop = 0;
        n = 0;
        @(negedge clk);
        reset_line_mode = mode;
        ans_en = en;
        ans_dly = dly;
        start = 1'b1;
        arm = 1'b1;
        // held until taken: after a reset-line answer the reset-high hold must run out first
        do begin
            @(negedge clk);
            n++;
        end while (status.busy !== 1'b1 && n < 400);
        start = 1'b0;
        arm = 1'b0;
        while ((status.busy !== 1'b0 || n < 2) && n < 2000) begin
            @(negedge clk);
            n++;
            if (card_clock_out === 1'b1 && clk_q === 1'b0) edges++;
            clk_q = card_clock_out;
            if (card_io_line_oe === 1'b1 && io_at < 0) io_at = edges;
            if (card_reset_out === 1'b1 && rise_at < 0) rise_at = edges;
            if (card_reset_out !== 1'b1 && rise_at >= 0) rst_drop = 1;
        end
        chk("busy", 16'h0000, {15'h0000, status.busy});
        // time zero is edge one, so four cycles after it is edge five
        chk("io assert", 16'h0001, {15'h0000, io_at >= 1 && io_at <= 5});
        chk("clock ran", 16'h0001, {15'h0000, edges > 0});
    endtask
    task automatic t_internal();
        run_seq(1'b0, 1'b1, 16'h000F);
        chk("answered", 16'h0001, {15'h0000, status.answered});
        chk("no timeout", 16'h0000, {15'h0000, status.timeout});
        chk("reset kept low", 16'h0001, {15'h0000, rise_at < 0});
    endtask
    task automatic t_reset_line();
        run_seq(1'b1, 1'b1, 16'h000F);
        chk("answered", 16'h0001, {15'h0000, status.answered});
        chk("low span", 16'h0001, {15'h0000, rise_at >= 20});
        chk("reset high", 16'h0001, {15'h0000, card_reset_out});
        chk("no drop", 16'h0000, rst_drop[15:0]);
    endtask
    // a card that never answers inside the window (silent, or only too early) must stop the clock and leave a sticky flag
    task automatic t_no_answer(input logic mode, input logic en, input logic [15:0] dly);
        run_seq(mode, en, dly);
        chk("timeout", 16'h0001, {15'h0000, status.timeout});
        chk("not answered", 16'h0000, {15'h0000, status.answered});
        repeat (8) @(negedge clk);
        chk("clock stopped", 16'h0000, {15'h0000, card_clock_out});
        chk("flag sticky", 16'h0001, {15'h0000, status.timeout});
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #(5 * 20000);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_internal();
        t_reset_line();
        t_no_answer(1'b1, 1'b0, 16'h0000);
        t_no_answer(1'b0, 1'b1, 16'h0006);
        t_reset_line();
        close_out();
    end
endmodule
